// ==== pwmc_cfg.svh ====
// constants for the left-aligned pwm channel timer
`ifndef PWMC_CFG_SVH
`define PWMC_CFG_SVH
`define PWMC_W         8
`define PWMC_ZERO      8'h00
`define PWMC_ONE       8'h01
`endif

// ==== pwmc_channel.sv ====
// one 8-bit left-aligned pwm channel timer with double-buffered period and duty
//
// Operation
// RULE1: polarity set: start high, low at duty
// RULE2: polarity clear: start low, high at duty
// RULE3: enabled: buffer writes until period end/counter write/disable
// RULE4: disabled: writes go straight to active latches
// RULE5: counter readable without disturbing anything
// RULE6: counter write clears, sets up, loads, restarts
// RULE7: disable holds count; enable resumes from it
// RULE8: disabled, period zero: counter resets next tick
// RULE9: dedicated 8-bit counter, one step per tick
// RULE10: duty match toggles output flip-flop
// RULE11: alignment clear: left-aligned, up count only
// RULE12: period match resets count, output, loads buffers
// RULE13: counts zero to period minus one
// RULE14: duty is high time or low time by polarity
// RULE15: software sets alignment before enabling
// RULE16: software writes counter before enabling for clean start
// RULE17: software writes values then counter to force
// RULE18: enable takes effect at next selected-clock tick
// RULE19: reset: disabled, not counting, direction up
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_cfg.svh"
module pwmc_channel
    import pwmc_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // selected prescaled clock tick
    input  wire logic                 clk_tick,
    // control bits
    input  wire logic                 channel_enable_bit,
    input  wire logic                 channel_polarity_bit,
    input  wire logic                 center_align_select,
    // register writes
    input  wire logic                 period_wr,
    input  wire logic [`PWMC_W-1:0]   period_wdata,
    input  wire logic                 duty_wr,
    input  wire logic [`PWMC_W-1:0]   duty_wdata,
    input  wire logic                 counter_wr,
    // readback
    output logic      [`PWMC_W-1:0]   channel_counter,
    output logic      [`PWMC_W-1:0]   period_buf_rd,
    output logic      [`PWMC_W-1:0]   duty_buf_rd,
    output logic                      count_down,
    // pin
    output logic                      pwm_out
);
    logic [`PWMC_W-1:0] cnt_reg, cnt_next;
    logic [`PWMC_W-1:0] per_buf_reg, per_buf_next;
    logic [`PWMC_W-1:0] dty_buf_reg, dty_buf_next;
    logic [`PWMC_W-1:0] per_act_reg, per_act_next;
    logic [`PWMC_W-1:0] dty_act_reg, dty_act_next;
    logic               ff_reg, ff_next;
    logic               run_reg, run_next;
    logic               en_d_reg, en_d_next;
    logic               out_reg, out_next;
    pwmc_dir_t          dir_reg, dir_next;
    logic               load;
    logic               per_match;

    // enable only takes hold at a tick edge, so the counter never starts mid-tick
    always_comb begin
        run_next = run_reg;
        if (clk_tick) begin
            run_next = channel_enable_bit; // RULE18
        end
        en_d_next = channel_enable_bit;
    end

    always_comb begin
        // match on count+1 so the counter wraps at period-1
        per_match = ((cnt_reg + `PWMC_ONE) == per_act_reg); // RULE13
        load      = 1'b0;
        cnt_next  = cnt_reg;
        ff_next   = ff_reg;
        dir_next  = PWMC_UP; // RULE11
        per_buf_next = period_wr ? period_wdata : per_buf_reg;
        dty_buf_next = duty_wr ? duty_wdata : dty_buf_reg;
        if (counter_wr) begin
            cnt_next = `PWMC_ZERO; // RULE6
            ff_next  = 1'b0;
            load     = 1'b1;
        end else if (run_reg && channel_enable_bit && clk_tick) begin // RULE7
            // run_reg lags enable until a tick, so gate on the live bit too
            if (per_match || per_act_reg == `PWMC_ZERO) begin
                cnt_next = `PWMC_ZERO; // RULE12
                ff_next  = 1'b0;
                load     = 1'b1;
            end else begin
                cnt_next = cnt_reg + `PWMC_ONE; // RULE9
                if ((cnt_reg + `PWMC_ONE) == dty_act_reg) begin
                    ff_next = ~ff_reg; // RULE10
                end
            end
        end else if (!channel_enable_bit && clk_tick && per_act_reg == `PWMC_ZERO) begin
            cnt_next = `PWMC_ZERO; // RULE8
        end
        // counter held while disabled, except a counter write or a tick with active period zero clears it
        if (!channel_enable_bit && en_d_reg) begin
            load = 1'b1; // RULE3 RULE7
        end
        per_act_next = per_act_reg;
        dty_act_next = dty_act_reg;
        if (load) begin
            per_act_next = per_buf_next; // RULE3
            dty_act_next = dty_buf_next;
        end
        if (!channel_enable_bit) begin
            if (period_wr) begin
                per_act_next = period_wdata; // RULE4
            end
            if (duty_wr) begin
                dty_act_next = duty_wdata; // RULE4
            end
        end
        // boundary cases: no duty, no period, duty at or beyond period
        if (per_act_reg == `PWMC_ZERO) begin
            out_next = ~channel_polarity_bit;
        end else if (dty_act_reg == `PWMC_ZERO || dty_act_reg >= per_act_reg) begin
            out_next = (dty_act_reg != `PWMC_ZERO) ~^ channel_polarity_bit;
        end else begin
            // level is first-half mux of the polarity bit or its inverse, not of the toggle flip-flop
            out_next = (cnt_reg < dty_act_reg) ? channel_polarity_bit : ~channel_polarity_bit; // RULE1 RULE2 RULE14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg     <= `PWMC_ZERO; // RULE19
            per_buf_reg <= `PWMC_ZERO;
            dty_buf_reg <= `PWMC_ZERO;
            per_act_reg <= `PWMC_ZERO;
            dty_act_reg <= `PWMC_ZERO;
            ff_reg      <= 1'b0;
            run_reg     <= 1'b0;
            en_d_reg    <= 1'b0;
            out_reg     <= 1'b0;
            dir_reg     <= PWMC_UP;
        end else begin
            cnt_reg     <= cnt_next;
            per_buf_reg <= per_buf_next;
            dty_buf_reg <= dty_buf_next;
            per_act_reg <= per_act_next;
            dty_act_reg <= dty_act_next;
            ff_reg      <= ff_next;
            run_reg     <= run_next;
            en_d_reg    <= en_d_next;
            out_reg     <= out_next;
            dir_reg     <= dir_next;
        end
    end

    // readback has no side effect on the count
    assign channel_counter = cnt_reg; // RULE5
    assign period_buf_rd   = per_buf_reg;
    assign duty_buf_rd     = dty_buf_reg;
    assign count_down      = dir_reg;
    assign pwm_out         = out_reg;

    property p_cnt_wr_clears;
        @(posedge ref_clk) disable iff (srst)
        counter_wr |=> (cnt_reg == `PWMC_ZERO && dir_reg == PWMC_UP);
    endproperty
    a_cnt_wr_clears: assert property (p_cnt_wr_clears) else $error("counter write did not clear"); // RULE6

    property p_hold_disabled;
        @(posedge ref_clk) disable iff (srst)
        (!run_reg && !counter_wr && per_act_reg != `PWMC_ZERO) |=> $stable(cnt_reg);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("counter moved while stopped"); // RULE7

    property p_below_period;
        @(posedge ref_clk) disable iff (srst)
        (run_reg && per_act_reg != `PWMC_ZERO && cnt_reg < per_act_reg) |=> (cnt_reg < $past(per_act_reg) || $past(load));
    endproperty
    a_below_period: assert property (p_below_period) else $error("counter reached period"); // RULE13

    property p_step;
        @(posedge ref_clk) disable iff (srst)
        (run_reg && channel_enable_bit && clk_tick && !counter_wr && !per_match && per_act_reg != `PWMC_ZERO)
            |=> cnt_reg == $past(cnt_reg) + `PWMC_ONE;
    endproperty
    a_step: assert property (p_step) else $error("counter did not advance"); // RULE9

    property p_dis_stop;
        @(posedge ref_clk) disable iff (srst)
        (!channel_enable_bit && !counter_wr && per_act_reg != `PWMC_ZERO) |=> $stable(cnt_reg);
    endproperty
    a_dis_stop: assert property (p_dis_stop) else $error("counter ran while disabled"); // RULE7

    property p_toggle;
        @(posedge ref_clk) disable iff (srst)
        (run_reg && channel_enable_bit && clk_tick && !counter_wr && dty_act_reg != `PWMC_ZERO
            && dty_act_reg < per_act_reg && (cnt_reg + `PWMC_ONE) == dty_act_reg)
            |=> ##1 pwm_out == ~$past(channel_polarity_bit);
    endproperty
    a_toggle: assert property (p_toggle) else $error("duty match did not flip output"); // RULE10

    property p_dis_direct;
        @(posedge ref_clk) disable iff (srst)
        (!channel_enable_bit && period_wr) |=> per_act_reg == $past(period_wdata);
    endproperty
    a_dis_direct: assert property (p_dis_direct) else $error("disabled write not direct"); // RULE4

    property p_buffered;
        @(posedge ref_clk) disable iff (srst)
        (channel_enable_bit && en_d_reg && !load) |=> $stable(per_act_reg);
    endproperty
    a_buffered: assert property (p_buffered) else $error("active period changed early"); // RULE3

    property p_start_level;
        @(posedge ref_clk) disable iff (srst)
        (cnt_reg == `PWMC_ZERO && dty_act_reg != `PWMC_ZERO && dty_act_reg < per_act_reg)
            |=> pwm_out == $past(channel_polarity_bit);
    endproperty
    a_start_level: assert property (p_start_level) else $error("wrong start level"); // RULE1 RULE2

    property p_up_only;
        @(posedge ref_clk) disable iff (srst)
        !center_align_select |-> dir_reg == PWMC_UP;
    endproperty
    a_up_only: assert property (p_up_only) else $error("direction not up"); // RULE11
endmodule
`default_nettype wire

// ==== pwmc_pkg.sv ====
// types for the left-aligned pwm channel timer
package pwmc_pkg;
    typedef enum logic [0:0] {
        PWMC_UP   = 1'b0,
        PWMC_DOWN = 1'b1
    } pwmc_dir_t;
endpackage

// ==== pwmc_testbench.sv ====
// self-checking bench for the left-aligned pwm channel timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pwmc_pkg::*;
    logic       ref_clk  = 1'b0;
    logic       srst     = 1'b1;
    logic       clk_tick = 1'b0;
    logic       en       = 1'b0;
    logic       pol      = 1'b0;
    logic       cae      = 1'b0;
    logic       per_wr   = 1'b0;
    logic       dty_wr   = 1'b0;
    logic       cnt_wr   = 1'b0;
    logic [7:0] wdata    = 8'h00;
    logic [7:0] cnt;
    logic [7:0] per_rd;
    logic [7:0] dty_rd;
    logic       dn;
    logic       pwm;
    // reference model of count, active and buffered compare values
    logic [7:0] m_cnt, m_per, m_dty, b_per, b_dty;
    logic       m_run;
    int         miscompares = 0;
    int         checks_done = 0;

    pwmc_channel DUT (
        .ref_clk              (ref_clk),
        .srst                 (srst),
        .clk_tick             (clk_tick),
        .channel_enable_bit   (en),
        .channel_polarity_bit (pol),
        .center_align_select  (cae),
        .period_wr            (per_wr),
        .period_wdata         (wdata),
        .duty_wr              (dty_wr),
        .duty_wdata           (wdata),
        .counter_wr           (cnt_wr),
        .channel_counter      (cnt),
        .period_buf_rd        (per_rd),
        .duty_buf_rd          (dty_rd),
        .count_down           (dn),
        .pwm_out              (pwm)
    );

    always #5 ref_clk = ~ref_clk;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // k: 0 period, 1 duty, 2 counter
    task wr(input int k, input logic [7:0] d);
        wdata  = d;
        per_wr = (k == 0);
        dty_wr = (k == 1);
        cnt_wr = (k == 2);
        @(negedge ref_clk);
        per_wr = 1'b0;
        dty_wr = 1'b0;
        cnt_wr = 1'b0;
        if (k == 0) b_per = d;
        if (k == 1) b_dty = d;
        if (k == 2 || !en) begin
            m_per = b_per;
            m_dty = b_dty;
        end
        if (k == 2) m_cnt = 8'h00;
    endtask

    task set_en(input logic v);
        en = v;
        @(negedge ref_clk);
        if (!v) begin
            m_per = b_per;
            m_dty = b_dty;
        end
    endtask

    // n ticks, each followed by a settle cycle so pwm_out has caught up with the count
    task step(input int n, input logic pc);
        logic e;
        repeat (n) begin
            clk_tick = 1'b1;
            @(negedge ref_clk);
            clk_tick = 1'b0;
            if (m_per == 8'h00) begin
                m_cnt = 8'h00;
            end else if (m_run && en) begin
                m_cnt = m_cnt + 8'h01;
                if (m_cnt == m_per) begin
                    m_cnt = 8'h00;
                    m_per = b_per;
                    m_dty = b_dty;
                end
            end
            m_run = en;
            @(negedge ref_clk);
            e = pol ? (m_cnt < m_dty) : (m_cnt >= m_dty);
            chk(cnt, m_cnt);
            if (pc) chk({7'h00, pwm}, {7'h00, e});
        end
    endtask

    task test_done;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        {m_cnt, m_per, m_dty, b_per, b_dty, m_run} = 41'h0;
        repeat (5) @(negedge ref_clk);
        srst = 1'b0;
        chk(cnt, 8'h00);
        chk({7'h00, dn}, 8'h00);
        wr(0, 8'h04);
        wr(1, 8'h01);
        chk(per_rd, 8'h04);
        chk(dty_rd, 8'h01);
        wr(2, 8'h00);
        set_en(1'b1);
        step(1, 1'b0);
        step(9, 1'b1);
        wr(1, 8'h03);
        chk(dty_rd, 8'h03);
        step(6, 1'b1);
        pol = 1'b1;
        wr(2, 8'h55);
        chk(cnt, 8'h00);
        step(5, 1'b1);
        wr(0, 8'h06);
        step(5, 1'b1);
        set_en(1'b0);
        step(3, 1'b0);
        set_en(1'b1);
        step(1, 1'b0);
        step(3, 1'b1);
        set_en(1'b0);
        wr(0, 8'h00);
        step(2, 1'b0);
        chk({7'h00, dn}, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
